// file: rtl/sfa_pkg.sv
// Constants and types for the serial frame access slave.
// Assumes a single core clock; the serial pins are asynchronous to it.
package sfa_pkg;

  // Field widths of the frame
  localparam int SFA_ADDR_W = 16;
  localparam int SFA_CNT_W = 15;
  localparam int SFA_BYTE_W = 8;

  // Header layout: byte index and bit positions
  localparam logic [1:0] SFA_HDR_ADDR_HI = 2'h0;
  localparam logic [1:0] SFA_HDR_ADDR_LO = 2'h1;
  localparam logic [1:0] SFA_HDR_RW_CNT = 2'h2;
  localparam logic [1:0] SFA_HDR_CNT_LO = 2'h3;
  localparam int SFA_RW_POS = 7;
  localparam logic [2:0] SFA_LAST_BIT = 3'h7;

  // Direction bit values
  localparam logic SFA_DIR_READ = 1'b0;
  localparam logic SFA_DIR_WRITE = 1'b1;

  // Reset values
  localparam logic [7:0] SFA_RST_BYTE = 8'h00;
  localparam logic [15:0] SFA_RST_ADDR = 16'h0000;
  localparam logic [14:0] SFA_RST_CNT = 15'h0000;

  // Core clock and output release time
  localparam int SFA_CLK_PERIOD_NS = 8;
  localparam int SFA_HIZ_NS = 5;
  localparam int SFA_HIZ_CYC = (SFA_HIZ_NS / SFA_CLK_PERIOD_NS) < 1 ? 1 :
                               (SFA_HIZ_NS / SFA_CLK_PERIOD_NS);

  // Frame phases
  typedef enum logic [1:0] {
    SFA_PH_IDLE = 2'b00,
    SFA_PH_HEADER = 2'b01,
    SFA_PH_DATA = 2'b10,
    SFA_PH_DONE = 2'b11
  } sfa_phase_t;

  // All state of the slave
  typedef struct packed {
    logic sclkS1;
    logic sclkS2;
    logic sclkS3;
    logic selS1;
    logic selS2;
    logic selS3;
    logic mosiS1;
    logic mosiS2;
    sfa_phase_t phase;
    logic [2:0] bitCnt;
    logic [1:0] byteCnt;
    logic sawRise;
    logic [7:0] rxShift;
    logic [15:0] addr;
    logic rwBit;
    logic [14:0] remain;
    logic [7:0] txShift;
    logic [7:0] nextByte;
    logic misoOut;
    logic misoOe;
    logic rdReq;
    logic [15:0] rdAddr;
    logic outValid;
    logic [15:0] outAddr;
    logic [7:0] outData;
    logic skidValid;
    logic [15:0] skidAddr;
    logic [7:0] skidData;
    logic overrun;
  } sfa_state_t;

endpackage : sfa_pkg

// file: rtl/sfa_spi_slave.sv
// Serial slave giving an external host byte access to an internal address space.
// Assumes serial pins asynchronous to clk, serial clock well below clk / 8,
// and an internal read port answering within a few clk cycles.
`timescale 1ns/100ps
`default_nettype none

module sfa_spi_slave
  import sfa_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclkPin,
  input wire logic slaveSelectLowN,
  input wire logic mosiPin,
  output logic misoOut,
  output logic misoOe,
  output logic rdReq,
  output logic [15:0] rdAddr,
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  output logic wrValid,
  output logic [15:0] wrAddr,
  output logic [7:0] wrData,
  input wire logic wrReady,
  output logic wrOverrun
);

  sfa_state_t q;
  sfa_state_t d;
  logic rise;
  logic fall;
  logic frameStart;
  logic frameEnd;
  logic byteDone;
  logic [7:0] rxByte;
  logic pop;
  logic push;
  logic dataByteTaken;

  // Next address of a burst
  function automatic logic [15:0] sfa_next_addr(input logic [15:0] a);
    sfa_next_addr = a + 16'h0001;
  endfunction : sfa_next_addr

  // Edge and frame detection on synchronised pins only
  assign rise = q.sclkS2 & ~q.sclkS3 & ~q.selS2;
  assign fall = ~q.sclkS2 & q.sclkS3 & ~q.selS2;
  assign frameStart = ~q.selS2 & q.selS3;
  assign frameEnd = q.selS2 & ~q.selS3;
  assign byteDone = rise & (q.bitCnt == SFA_LAST_BIT);
  assign rxByte = {q.rxShift[6:0], q.mosiS2};
  assign pop = q.outValid & wrReady;
  assign dataByteTaken = byteDone & (q.phase == SFA_PH_DATA) & (q.remain != SFA_RST_CNT);
  assign push = dataByteTaken & (q.rwBit == SFA_DIR_WRITE);

  // Next state of the whole slave
  always_comb begin
    d = q;
    d.sclkS1 = sclkPin;
    d.sclkS2 = q.sclkS1;
    d.sclkS3 = q.sclkS2;
    d.selS1 = slaveSelectLowN;
    d.selS2 = q.selS1;
    d.selS3 = q.selS2;
    d.mosiS1 = mosiPin;
    d.mosiS2 = q.mosiS1;
    d.rdReq = 1'b0;
    // Drive output while selected, release when deselected
    d.misoOe = ~q.selS2;
    // Frame start: clear counters, no assumption on clock idle level
    if (frameStart) begin
      d.phase = SFA_PH_HEADER;
      d.bitCnt = 3'h0;
      d.byteCnt = SFA_HDR_ADDR_HI;
      d.sawRise = 1'b0;
      d.txShift = SFA_RST_BYTE;
      d.nextByte = SFA_RST_BYTE;
      d.misoOut = 1'b0;
      d.overrun = 1'b0;
    end
    if (frameEnd) begin
      d.phase = SFA_PH_IDLE;
    end
    // Sample on rising edge
    if (rise) begin
      d.rxShift = rxByte;
      d.bitCnt = q.bitCnt + 3'h1;
      d.sawRise = 1'b1;
    end
    // Header decode, address high byte first
    if (byteDone && q.phase == SFA_PH_HEADER) begin
      d.byteCnt = q.byteCnt + 2'h1;
      unique case (q.byteCnt)
        SFA_HDR_ADDR_HI: d.addr[15:8] = rxByte;
        SFA_HDR_ADDR_LO: d.addr[7:0] = rxByte;
        SFA_HDR_RW_CNT: begin
          d.rwBit = rxByte[SFA_RW_POS];
          d.remain[14:8] = rxByte[6:0];
        end
        SFA_HDR_CNT_LO: begin
          d.remain[7:0] = rxByte;
          d.phase = ({q.remain[14:8], rxByte} == SFA_RST_CNT) ? SFA_PH_DONE : SFA_PH_DATA;
          // Fetch first read byte ahead of its first bit
          if (q.rwBit == SFA_DIR_READ && {q.remain[14:8], rxByte} != SFA_RST_CNT) begin
            d.rdReq = 1'b1;
            d.rdAddr = q.addr;
          end
        end
      endcase
    end
    // Data bytes: count down, advance address, prefetch next read
    if (dataByteTaken) begin
      d.remain = q.remain - 15'h0001;
      d.addr = sfa_next_addr(q.addr);
      if (q.remain == 15'h0001) begin
        d.phase = SFA_PH_DONE;
      end
      if (q.rwBit == SFA_DIR_READ && q.remain > 15'h0001) begin
        d.rdReq = 1'b1;
        d.rdAddr = sfa_next_addr(q.addr);
      end
    end
    // Read data waits here until its byte starts
    if (rdValid) begin
      d.nextByte = rdData;
    end
    // Change output on falling edge, only after a rising edge
    if (fall && q.sawRise) begin
      if (q.bitCnt == 3'h0) begin
        d.misoOut = q.nextByte[7];
        d.txShift = {q.nextByte[6:0], 1'b0};
        d.nextByte = rdValid ? rdData : SFA_RST_BYTE;
      end else begin
        d.misoOut = q.txShift[7];
        d.txShift = {q.txShift[6:0], 1'b0};
      end
    end
    // Two-entry write buffer: head stage then skid stage
    if (pop) begin
      d.outValid = q.skidValid;
      d.outAddr = q.skidAddr;
      d.outData = q.skidData;
      d.skidValid = 1'b0;
    end
    if (push) begin
      if (!d.outValid) begin
        d.outValid = 1'b1;
        d.outAddr = q.addr;
        d.outData = rxByte;
      end else if (!d.skidValid) begin
        d.skidValid = 1'b1;
        d.skidAddr = q.addr;
        d.skidData = rxByte;
      end else begin
        d.overrun = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{sclkS1: 1'b0, sclkS2: 1'b0, sclkS3: 1'b0,
             selS1: 1'b1, selS2: 1'b1, selS3: 1'b1,
             mosiS1: 1'b0, mosiS2: 1'b0, phase: SFA_PH_IDLE,
             bitCnt: 3'h0, byteCnt: SFA_HDR_ADDR_HI, sawRise: 1'b0,
             rxShift: SFA_RST_BYTE, addr: SFA_RST_ADDR, rwBit: SFA_DIR_READ,
             remain: SFA_RST_CNT, txShift: SFA_RST_BYTE, nextByte: SFA_RST_BYTE,
             misoOut: 1'b0, misoOe: 1'b0, rdReq: 1'b0, rdAddr: SFA_RST_ADDR,
             outValid: 1'b0, outAddr: SFA_RST_ADDR, outData: SFA_RST_BYTE,
             skidValid: 1'b0, skidAddr: SFA_RST_ADDR, skidData: SFA_RST_BYTE,
             overrun: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign misoOut = q.misoOut;
  assign misoOe = q.misoOe;
  assign rdReq = q.rdReq;
  assign rdAddr = q.rdAddr;
  assign wrValid = q.outValid;
  assign wrAddr = q.outAddr;
  assign wrData = q.outData;
  assign wrOverrun = q.overrun;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_oe_follow_sel: assert property (
    ($fell(q.selS2) |=> misoOe [*2]) and ($rose(q.selS2) |=> !misoOe [*2]))
    else $error("output enable does not follow select");

  chk_header_out_low: assert property (
    (misoOe && q.phase == SFA_PH_HEADER) |-> !misoOut)
    else $error("output not low during header");

  chk_out_on_fall: assert property (
    ($changed(misoOut) && $past(!frameStart)) |-> $past(fall))
    else $error("output changed away from falling edge");

  chk_sample_on_rise: assert property (
    ($changed(q.bitCnt) && !$past(frameStart)) |-> $past(rise))
    else $error("bit counter moved without rising edge");

  chk_start_clears: assert property (
    frameStart |=> (!q.sawRise && q.bitCnt == 3'h0 && q.phase == SFA_PH_HEADER))
    else $error("frame start did not clear bit state");

  chk_header_len: assert property (
    $rose(q.phase == SFA_PH_DATA) |-> ($past(q.byteCnt) == SFA_HDR_CNT_LO && $past(byteDone)))
    else $error("data phase began before four header bytes");

  chk_read_only_req: assert property (
    rdReq |-> (q.rwBit == SFA_DIR_READ && $past(byteDone)))
    else $error("read request outside a read frame");

  chk_write_push: assert property (
    push |=> (wrValid && q.overrun == $past(q.overrun) || q.skidValid || q.overrun))
    else $error("write byte was not buffered");

  chk_addr_advance: assert property (
    dataByteTaken |=> q.addr == sfa_next_addr($past(q.addr)))
    else $error("burst address did not advance by one");

  chk_burst_end: assert property (
    (dataByteTaken && q.remain == 15'h0001) |=> q.phase == SFA_PH_DONE)
    else $error("burst did not stop at its count");

  cov_read_burst: cover property (rdReq ##[1:400] rdReq);
  cov_write_burst: cover property (push ##[1:400] push);
  cov_mode3_start: cover property (frameStart && q.sclkS2);
  cov_buffer_full: cover property (q.outValid && q.skidValid);

endmodule : sfa_spi_slave

`default_nettype wire

// file: tb/sfa_host_model.sv
// Host-side serial master model driving select, clock and data out.
// Assumes the bench resolves the device's data line and shares its core clock;
// every pin changes by non-blocking assignment at a rising core clock edge.
`timescale 1ns/100ps
`default_nettype none

module sfa_host_model (
  input wire logic clk,
  output logic sclkPin,
  output logic slaveSelectLowN,
  output logic mosiPin,
  input wire logic misoPin
);
  // Half a link clock period in core cycles, 160 ns per link bit
  localparam int HALF_CYC = 10;
  bit idleHigh;

  // Idle: deselected, clock low
  initial begin
    sclkPin = 1'b0;
    slaveSelectLowN = 1'b1;
    mosiPin = 1'b1;
  end

  // Open a frame in mode 0 or 3
  task automatic open_frame(input bit mode3);
    @(posedge clk);
    idleHigh = mode3;
    sclkPin <= mode3;
    repeat (5) @(posedge clk);
    slaveSelectLowN <= 1'b0;
    mosiPin <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : open_frame

  // One byte MSB first: change on falling, sample on rising
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      sclkPin <= 1'b0;
      mosiPin <= tx[i];
      repeat (HALF_CYC) @(posedge clk);
      sclkPin <= 1'b1;
      rx[i] = misoPin;
      repeat (HALF_CYC) @(posedge clk);
    end
    // Mode 0 goes back to its low idle level
    if (!idleHigh) begin
      sclkPin <= 1'b0;
    end
  endtask : xfer

  // Close; the host data line flips so a stale level is not kept
  task automatic close_frame();
    repeat (HALF_CYC) @(posedge clk);
    slaveSelectLowN <= 1'b1;
    mosiPin <= ~mosiPin;
    repeat (5) @(posedge clk);
  endtask : close_frame
endmodule : sfa_host_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the serial frame access slave.
// Assumes the host model drives the serial pins; this bench serves the internal ports.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module testbench;
  import sfa_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sclkPin, slaveSelectLowN, mosiPin, misoPin, misoOut, misoOe, rdReq;
  logic wrValid, wrOverrun;
  logic rdValid = 1'b0;
  logic wrReady = 1'b0;
  logic lastMiso = 1'b0;
  logic [1:0] rdPipe = 2'h0;
  logic [15:0] rdAddr, wrAddr;
  logic [7:0] rdData = 8'h00;
  logic [7:0] wrData;
  logic [23:0] wrLog[$];
  logic [7:0] rxb[3];
  int n_errors = 0;
  int n_checks = 0;

  always #4 clk = ~clk;

  sfa_host_model i_host (.clk(clk), .sclkPin(sclkPin), .slaveSelectLowN(slaveSelectLowN),
    .mosiPin(mosiPin), .misoPin(misoPin));
  sfa_spi_slave i_dut (.clk(clk), .nrst(nrst), .sclkPin(sclkPin),
    .slaveSelectLowN(slaveSelectLowN), .mosiPin(mosiPin), .misoOut(misoOut),
    .misoOe(misoOe), .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData),
    .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData), .wrReady(wrReady),
    .wrOverrun(wrOverrun));

  // Released data line shows the inverse of its last driven level
  always @(posedge clk) if (misoOe === 1'b1) lastMiso <= misoOut;
  assign misoPin = (misoOe === 1'b1) ? misoOut : ~lastMiso;

  function automatic logic [7:0] rd_pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction : rd_pat

  // Read port answers in the third cycle; taken writes are logged
  always @(posedge clk) begin
    rdPipe <= {rdPipe[0], rdReq === 1'b1};
    rdValid <= rdPipe[1];
    rdData <= rd_pat(rdAddr);
    if (wrValid === 1'b1 && wrReady) wrLog.push_back({wrAddr, wrData});
  end

  // One frame: header, then n bytes taken from d
  task automatic frame(input bit m3, input logic [15:0] a, input logic rw,
      input logic [14:0] n, input logic [23:0] d);
    logic [7:0] r;
    i_host.open_frame(m3);
    #1;
    `CHK(misoOe, 1'b1)
    `CHK(misoOut, 1'b0)
    i_host.xfer(a[15:8], r);
    i_host.xfer(a[7:0], r);
    i_host.xfer({rw, n[14:8]}, r);
    i_host.xfer(n[7:0], r);
    for (int k = 0; k < n; k++) i_host.xfer(d[23-8*k -: 8], rxb[k]);
    i_host.close_frame();
    repeat (6) @(posedge clk);
    #1;
    `CHK(misoOe, 1'b0)
  endtask : frame

  // Reads: single in mode 0, burst across the address wrap in mode 3
  task automatic t_reads();
    frame(1'b0, 16'h1234, 1'b0, 15'h0001, 24'h000000);
    `CHK(rxb[0], rd_pat(16'h1234))
    frame(1'b1, 16'hFFFE, 1'b0, 15'h0003, 24'h000000);
    `CHK(rxb[0], rd_pat(16'hFFFE))
    `CHK(rxb[1], rd_pat(16'hFFFF))
    `CHK(rxb[2], rd_pat(16'h0000))
    `CHK(wrLog.size(), 0)
  endtask : t_reads

  // Single write, then a count of zero that writes nothing
  task automatic t_write_one();
    @(posedge clk) wrReady <= 1'b1;
    frame(1'b0, 16'h4321, 1'b1, 15'h0001, 24'hC30000);
    frame(1'b0, 16'h2222, 1'b1, 15'h0000, 24'h770000);
    `CHK(wrLog.size(), 1)
    `CHK(wrLog[0], 24'h4321C3)
    `CHK(wrOverrun, 1'b0)
  endtask : t_write_one

  // Burst write into a stalled receiver: two held, third lost
  task automatic t_write_stall();
    @(posedge clk) wrReady <= 1'b0;
    wrLog.delete();
    frame(1'b1, 16'h00FF, 1'b1, 15'h0003, 24'h5AA53C);
    `CHK(wrOverrun, 1'b1)
    `CHK(wrValid, 1'b1)
    @(posedge clk) wrReady <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK(wrLog.size(), 2)
    `CHK(wrLog[0], 24'h00FF5A)
    `CHK(wrLog[1], 24'h0100A5)
    `CHK(wrValid, 1'b0)
  endtask : t_write_stall

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    `CHK(misoOe, 1'b0)
    `CHK(wrValid, 1'b0)
    @(posedge clk) nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reads();
    t_write_one();
    t_write_stall();
    stop_test();
  end

  // Watchdog
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end

  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
endmodule : testbench
`default_nettype wire
